// ### ipmcf_pkg.sv
// Function
// - bit 4 forwards listener discovery, else drop
// - listener class needs dest 33:33:00:00:00:01
// - both classes need EtherType 0x86dd
// - both classes need Next Header 58
// - listener class needs ICMPv6 type 130-132
// - bit 5 forwards solicitation, else drop
// - solicitation matches only dest prefix 33:33:ff
// - solicitation class needs ICMPv6 type 135
// - each class filter support is optional
// - enabled solicitation passes every target address
package ipmcf_pkg;
   localparam int unsigned IPMCF_DATA_W = 8;
   localparam int unsigned IPMCF_FIFO_DEPTH = 4;
   localparam int unsigned IPMCF_EN_W = 32;
   localparam int unsigned IPMCF_BIT_MLD = 4;
   localparam int unsigned IPMCF_BIT_NS = 5;
   localparam logic [47:0] IPMCF_MAC_ALLNODES = 48'h3333_0000_0001;
   localparam logic [23:0] IPMCF_MAC_SNODE = 24'h3333ff;
   localparam logic [15:0] IPMCF_ETYPE_IPV6 = 16'h86dd;
   localparam logic [7:0] IPMCF_NH_ICMPV6 = 8'h3a;
   localparam logic [7:0] IPMCF_TYPE_QUERY = 8'h82;
   localparam logic [7:0] IPMCF_TYPE_REPORT = 8'h83;
   localparam logic [7:0] IPMCF_TYPE_DONE = 8'h84;
   localparam logic [7:0] IPMCF_TYPE_NSOL = 8'h87;
   // byte offsets within the frame
   localparam logic [6:0] IPMCF_OFS_ETYPE_HI = 7'h0c;
   localparam logic [6:0] IPMCF_OFS_ETYPE_LO = 7'h0d;
   localparam logic [6:0] IPMCF_OFS_NH = 7'h14;
   localparam logic [6:0] IPMCF_OFS_ICMP = 7'h36;
   localparam logic [6:0] IPMCF_OFS_MAC_END = 7'h05;
   localparam logic [6:0] IPMCF_OFS_MAX = 7'h7f;
   localparam logic [6:0] IPMCF_OFS_SN_END = 7'h02;
   // verdict byte fields
   localparam int unsigned IPMCF_VB_FWD = 0;
   localparam int unsigned IPMCF_VB_MLD = 1;
   localparam int unsigned IPMCF_VB_NS = 2;
   typedef enum logic [2:0] {
      IPMCF_ST_HDR = 3'b001,
      IPMCF_ST_SKIP = 3'b010,
      IPMCF_ST_DONE = 3'b100
   } ipmcf_state_e;
endpackage

// ### ipmcf_fifo.sv
`timescale 1ns/100ps
module ipmcf_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // write side
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   input wire logic [WIDTH-1:0] wr_data_i,
   // read side
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [WIDTH-1:0] rd_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   assign wr_ready_o = (count_q != (AW+1)'(DEPTH));
   assign rd_valid_o = (count_q != '0);
   assign push = wr_valid_i && wr_ready_o;
   assign pop = rd_valid_o && rd_ready_i;
   assign rd_data_o = mem_q[rd_ptr_q];

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= wr_data_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // ipmcf_fifo

// ### ipmcf_filter.sv
`timescale 1ns/100ps
module ipmcf_filter import ipmcf_pkg::*; #(
   parameter bit MLD_SUPPORTED = 1'b1,
   parameter bit NS_SUPPORTED = 1'b1
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // filter enable word from the multicast filter command
   input wire logic [IPMCF_EN_W-1:0] filter_en_i,
   // received frame bytes
   input wire logic rx_valid_i,
   output logic rx_ready_o,
   input wire logic [IPMCF_DATA_W-1:0] rx_data_i,
   input wire logic rx_last_i,
   // classification verdict toward pass-through path
   output logic verdict_valid_o,
   input wire logic verdict_ready_i,
   output logic [IPMCF_DATA_W-1:0] verdict_o
);
   ipmcf_state_e state_q;
   logic [6:0] ofs_q;
   logic mac_all_q;
   logic mac_sn_q;
   logic etype_ok_q;
   logic nh_ok_q;
   logic mld_type_q;
   logic ns_type_q;
   logic mld_en;
   logic ns_en;
   logic mld_hit;
   logic ns_hit;
   logic in_hdr;
   logic at_type;
   logic type_mld_now;
   logic type_ns_now;
   logic mld_type;
   logic ns_type;
   logic take;
   logic eof;
   logic [7:0] exp_all;
   logic [7:0] exp_sn;
   logic fifo_wr_ready;
   logic fifo_wr_valid;
   logic [IPMCF_DATA_W-1:0] fifo_wr_data;

   // only bits 4 and 5 are looked at; unsupported classes always drop
   assign mld_en = filter_en_i[IPMCF_BIT_MLD] && MLD_SUPPORTED;
   assign ns_en = filter_en_i[IPMCF_BIT_NS] && NS_SUPPORTED;

   // a frame's last byte is held off while the verdict fifo is full
   assign rx_ready_o = !(rx_last_i && !fifo_wr_ready);
   assign take = rx_valid_i && rx_ready_o;
   assign eof = take && rx_last_i;

   always_comb begin
      exp_all = 8'h00;
      exp_sn = 8'h00;
      // guarded so the part-selects never run past the address constants
      if (ofs_q <= IPMCF_OFS_MAC_END) begin
         exp_all = IPMCF_MAC_ALLNODES[47 - 8*ofs_q[2:0] -: 8];
      end
      if (ofs_q <= IPMCF_OFS_SN_END) begin
         exp_sn = IPMCF_MAC_SNODE[23 - 8*ofs_q[1:0] -: 8];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ofs_q <= '0;
      end else if (eof) begin
         ofs_q <= '0;
      end else if (take && ofs_q != IPMCF_OFS_MAX) begin
         ofs_q <= ofs_q + 7'h01;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_q <= IPMCF_ST_HDR;
      end else begin
         case (state_q)
            IPMCF_ST_HDR: begin
               if (eof) begin
                  state_q <= IPMCF_ST_HDR;
               end else if (take && ofs_q == IPMCF_OFS_ICMP) begin
                  state_q <= IPMCF_ST_SKIP;
               end
            end
            IPMCF_ST_SKIP: begin
               if (eof) begin
                  state_q <= IPMCF_ST_HDR;
               end
            end
            default: begin
               state_q <= IPMCF_ST_HDR;
            end
         endcase
      end
   end

   // only header bytes count; payload bytes never touch the flags
   assign in_hdr = take && state_q == IPMCF_ST_HDR;
   // the type byte may also be a frame's last byte, so it is decoded
   // straight from the input as well as stored
   assign at_type = in_hdr && ofs_q == IPMCF_OFS_ICMP;
   assign type_mld_now = (rx_data_i == IPMCF_TYPE_QUERY) ||
                         (rx_data_i == IPMCF_TYPE_REPORT) ||
                         (rx_data_i == IPMCF_TYPE_DONE);
   assign type_ns_now = (rx_data_i == IPMCF_TYPE_NSOL);

   // match flags start true at frame start and are knocked down per byte
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || eof) begin
         mac_all_q <= 1'b1;
      end else if (in_hdr && ofs_q <= IPMCF_OFS_MAC_END &&
                   rx_data_i != exp_all) begin
         mac_all_q <= 1'b0;
      end
   end

   // the low three address bytes carry the target and are not compared
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || eof) begin
         mac_sn_q <= 1'b1;
      end else if (in_hdr && ofs_q <= IPMCF_OFS_SN_END &&
                   rx_data_i != exp_sn) begin
         mac_sn_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i || eof) begin
         etype_ok_q <= 1'b1;
      end else if (in_hdr && ofs_q == IPMCF_OFS_ETYPE_HI &&
                   rx_data_i != IPMCF_ETYPE_IPV6[15:8]) begin
         etype_ok_q <= 1'b0;
      end else if (in_hdr && ofs_q == IPMCF_OFS_ETYPE_LO &&
                   rx_data_i != IPMCF_ETYPE_IPV6[7:0]) begin
         etype_ok_q <= 1'b0;
      end
   end

   // extension headers are not walked, so they make both classes miss
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || eof) begin
         nh_ok_q <= 1'b1;
      end else if (in_hdr && ofs_q == IPMCF_OFS_NH &&
                   rx_data_i != IPMCF_NH_ICMPV6) begin
         nh_ok_q <= 1'b0;
      end
   end

   // type flags start false, so frames ending before the type never match
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || eof) begin
         mld_type_q <= 1'b0;
         ns_type_q <= 1'b0;
      end else if (at_type) begin
         mld_type_q <= type_mld_now;
         ns_type_q <= type_ns_now;
      end
   end

   assign mld_type = mld_type_q || (at_type && type_mld_now);
   assign ns_type = ns_type_q || (at_type && type_ns_now);
   assign mld_hit = mac_all_q && etype_ok_q && nh_ok_q && mld_type;
   assign ns_hit = mac_sn_q && etype_ok_q && nh_ok_q && ns_type;

   // verdict byte: bit0 forward, bit1 mld class, bit2 ns class
   assign fifo_wr_valid = eof;
   always_comb begin
      fifo_wr_data = '0;
      fifo_wr_data[IPMCF_VB_MLD] = mld_hit;
      fifo_wr_data[IPMCF_VB_NS] = ns_hit;
      fifo_wr_data[IPMCF_VB_FWD] = (mld_hit && mld_en) ||
                                   (ns_hit && ns_en);
   end

   ipmcf_fifo #(
      .WIDTH(IPMCF_DATA_W),
      .DEPTH(IPMCF_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .wr_valid_i(fifo_wr_valid),
      .wr_ready_o(fifo_wr_ready),
      .wr_data_i(fifo_wr_data),
      .rd_valid_o(verdict_valid_o),
      .rd_ready_i(verdict_ready_i),
      .rd_data_o(verdict_o)
   );
endmodule // ipmcf_filter

// ### ipmcf_filter_assertions.sv
`timescale 1ns/100ps
module ipmcf_filter_chk import ipmcf_pkg::*; (
   // watched ports
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic rx_valid_i,
   input wire logic rx_ready_o,
   input wire logic rx_last_i,
   input wire logic verdict_valid_o,
   input wire logic verdict_ready_i,
   input wire logic [IPMCF_DATA_W-1:0] verdict_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   sequence s_last_taken;
      rx_valid_i && rx_ready_o && rx_last_i;
   endsequence
   sequence s_held;
      verdict_valid_o && !verdict_ready_i;
   endsequence
   chk_answer_next: assert property (s_last_taken |=> verdict_valid_o)
      else $error("no verdict after last byte");
   chk_verdict_hold: assert property (s_held |=> verdict_valid_o
      && $stable(verdict_o)) else $error("verdict changed unpopped");
   chk_stall_last: assert property (!rx_ready_o |-> rx_last_i
      && verdict_valid_o) else $error("stall without full queue");
   chk_pad_zero: assert property (verdict_valid_o |-> verdict_o[7:3]
      == 5'h00) else $error("verdict spare bits set");
   chk_class_excl: assert property (verdict_valid_o
      |-> !(verdict_o[1] && verdict_o[2])) else $error("both classes");
   chk_fwd_hit: assert property (verdict_valid_o && verdict_o[0]
      |-> verdict_o[1] || verdict_o[2]) else $error("forward no class");
   chk_pop_only: assert property ($fell(verdict_valid_o)
      |-> $past(verdict_ready_i)) else $error("verdict lost");
   chk_reset_empty: assert property ($fell(reset_i) |-> !verdict_valid_o)
      else $error("verdict after reset");
endmodule // ipmcf_filter_chk
bind ipmcf_filter ipmcf_filter_chk ipmcf_filter_chk_inst (.sys_clk_i,
   .reset_i, .rx_valid_i, .rx_ready_o, .rx_last_i, .verdict_valid_o,
   .verdict_ready_i, .verdict_o);

// ### ipmcf_mc_model.sv
`timescale 1ns/100ps
module ipmcf_mc_model (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // pacing from the bench
   input wire logic stall_i,
   input wire logic slow_i,
   // verdict pop
   output logic verdict_ready_o
);
   logic ph_q;
   // slow mode pops every other cycle to keep the queue half busy
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) ph_q <= 1'b0;
      else ph_q <= ~ph_q;
   end
   assign verdict_ready_o = !stall_i && (!slow_i || ph_q);
endmodule // ipmcf_mc_model

// ### ipv6_multicast_class_filter_test.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
   mismatches++; $display("unexpected %s exp %h got %h", n, e, s); end end
module ipv6_multicast_class_filter_test import ipmcf_pkg::*;;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [IPMCF_EN_W-1:0] filter_en_i = 32'h0;
   logic rx_valid_i = 1'b0;
   logic rx_last_i = 1'b0;
   logic [7:0] rx_data_i = 8'h00;
   logic stall = 1'b0;
   logic slow = 1'b0;
   logic rx_ready_o, verdict_valid_o, verdict_ready_i;
   logic omit_valid;
   logic [7:0] omit_verdict;
   logic [7:0] verdict_o, ev;
   logic [7:0] exp_q[$];
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   always #20 sys_clk_i = ~sys_clk_i;
   ipmcf_filter ipmcf_filter_inst (.sys_clk_i, .reset_i, .filter_en_i,
      .rx_valid_i, .rx_ready_o, .rx_data_i, .rx_last_i, .verdict_valid_o,
      .verdict_ready_i, .verdict_o);
   // same traffic into a copy with both classes omitted
   ipmcf_filter #(.MLD_SUPPORTED(1'b0), .NS_SUPPORTED(1'b0))
      ipmcf_filter_omit_inst (.sys_clk_i, .reset_i, .filter_en_i,
      .rx_valid_i, .rx_ready_o(), .rx_data_i, .rx_last_i,
      .verdict_valid_o(omit_valid), .verdict_ready_i,
      .verdict_o(omit_verdict));
   ipmcf_mc_model ipmcf_mc_model_inst (.sys_clk_i, .reset_i,
      .stall_i(stall), .slow_i(slow), .verdict_ready_o(verdict_ready_i));
   task give_verdict;
      if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // negedge view: combinational outputs have settled after the pop edge
   always @(negedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         give_verdict();
      end
      if (verdict_valid_o === 1'b1 && verdict_ready_i === 1'b1) begin
         ev = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
         `CHK("verdict_o", ev, verdict_o)
         `CHK("omit_valid", 1'b1, omit_valid)
         `CHK("omit_verdict", ev & 8'hfe, omit_verdict)
      end
   end
   task automatic put(input logic [7:0] d, input logic l);
      rx_valid_i <= 1'b1;
      rx_data_i <= d;
      rx_last_i <= l;
      @(negedge sys_clk_i);
      while (rx_ready_o !== 1'b1) @(negedge sys_clk_i);
      @(posedge sys_clk_i);
   endtask
   function automatic logic [7:0] fb(logic [47:0] m, logic [15:0] e,
      logic [7:0] n, logic [7:0] t, int i);
      if (i < 6) return m[47-8*i -: 8];
      case (i)
         12: return e[15:8];
         13: return e[7:0];
         20: return n;
         54: return t;
         default: return 8'(i);
      endcase
   endfunction
   task automatic frame(logic [47:0] m, logic [15:0] e, logic [7:0] n,
      logic [7:0] t, logic [31:0] en, int len = 64);
      logic mld, ns;
      mld = m == 48'h333300000001 && e == 16'h86dd && n == 8'h3a
         && t >= 8'h82 && t <= 8'h84 && len > 54;
      ns = m[47:24] == 24'h3333ff && e == 16'h86dd && n == 8'h3a
         && t == 8'h87 && len > 54;
      exp_q.push_back({5'h00, ns, mld, mld && en[4] || ns && en[5]});
      filter_en_i <= en;
      for (int i = 0; i < len; i++) put(fb(m, e, n, t, i), i == len - 1);
   endtask
   task automatic drain;
      rx_valid_i <= 1'b0;
      for (int k = 0; k < 300 && exp_q.size() > 0; k++) @(negedge sys_clk_i);
      @(negedge sys_clk_i);
      `CHK("verdict_valid_o", 1'b0, verdict_valid_o)
      `CHK("pending", 0, exp_q.size())
      @(posedge sys_clk_i);
   endtask
   task automatic t_mld;
      for (int t = 129; t <= 133; t++)
         frame(48'h333300000001, 16'h86dd, 8'h3a, 8'(t), 32'h10);
      frame(48'h333300000001, 16'h86dd, 8'h3a, 8'h83, 32'h20);
      drain();
   endtask
   task automatic t_ns;
      slow <= 1'b1;
      for (int t = 134; t <= 136; t++)
         frame(48'h3333ff0a0b0c, 16'h86dd, 8'h3a, 8'(t), 32'h20);
      frame(48'h3333ffffffff, 16'h86dd, 8'h3a, 8'h87, 32'h30);
      frame(48'h3333ff000000, 16'h86dd, 8'h3a, 8'h87, 32'h10);
      drain();
   endtask
   task automatic t_bad;
      slow <= 1'b0;
      frame(48'h333300000002, 16'h86dd, 8'h3a, 8'h82, 32'h30);
      frame(48'h3333fe000001, 16'h86dd, 8'h3a, 8'h87, 32'h30);
      frame(48'h333300000001, 16'h0800, 8'h3a, 8'h82, 32'h30);
      frame(48'h3333ff000001, 16'h86dd, 8'h11, 8'h87, 32'h30);
      frame(48'h333300000001, 16'h86dd, 8'h3a, 8'h82, 32'hffffffc0);
      drain();
   endtask
   task automatic t_full;
      stall <= 1'b1;
      repeat (4) frame(48'h0, 16'h0, 8'h0, 8'h0, 32'h30);
      exp_q.push_back(8'h00);
      repeat (3) @(negedge sys_clk_i);
      `CHK("rx_ready_o", 1'b0, rx_ready_o)
      @(posedge sys_clk_i);
      stall <= 1'b0;
      put(8'h3f, 1'b1);
      drain();
   endtask
   task automatic t_reset;
      stall <= 1'b1;
      frame(48'h333300000001, 16'h86dd, 8'h3a, 8'h82, 32'h10);
      for (int i = 0; i < 20; i++) put(8'(i), 1'b0);
      reset_i <= 1'b1;
      rx_valid_i <= 1'b0;
      exp_q.delete();
      repeat (2) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      stall <= 1'b0;
      @(negedge sys_clk_i);
      `CHK("verdict_valid_o", 1'b0, verdict_valid_o)
      `CHK("omit_valid", 1'b0, omit_valid)
      @(posedge sys_clk_i);
      frame(48'h333300000001, 16'h86dd, 8'h3a, 8'h84, 32'h10, 55);
      frame(48'h3333ff000001, 16'h86dd, 8'h3a, 8'h87, 32'h20, 54);
      drain();
   endtask
   initial begin
      repeat (6) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      t_mld();
      t_ns();
      t_bad();
      t_full();
      t_reset();
      give_verdict();
   end
endmodule // ipv6_multicast_class_filter_test
